// [bench/csr_engine_model.sv]
`timescale 1ns/1ps
// stand-in for the protocol engine and the nodes beyond it
module csr_engine_model
  import csr_pkg::*;
(
  // clock
  input wire logic clk,
  // engine outputs toward the block
  output csr_pkg::csr_evt_t evt,
  output csr_pkg::csr_err_t err,
  output logic collect,
  output logic [4:0] collect_obj,
  // objects the block lets us send
  input wire logic [31:0] send_allow
);
  // quiet engine at time zero
  initial begin
    evt = '0;
    err = '0;
    collect = 1'b0;
    collect_obj = 5'h00;
  end

  // one-cycle event; idle fields carry junk so stale values never help
  task automatic pulse(input csr_evt_t e);
    csr_evt_t idle;
    idle = ($bits(idle))'($urandom);
    idle.rx_done = 1'b0;
    idle.tx_done = 1'b0;
    idle.tx_err = 1'b0;
    idle.err_valid = 1'b0;
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= idle;
  endtask

  // correctly received frame, filter hit or miss
  task automatic receive(input logic [4:0] ob, input logic m);
    csr_evt_t e;
    e = '0;
    e.rx_done = 1'b1;
    e.rx_obj = ob;
    e.rx_match = m;
    pulse(e);
  endtask

  // end of own frame, good or errored
  task automatic transmit(input logic [4:0] ob, input logic bad,
                          input csr_lec_t code);
    csr_evt_t e;
    e = '0;
    e.tx_done = 1'b1;
    e.tx_err = bad;
    e.tx_obj = ob;
    e.err_code = code;
    e.err_valid = bad;
    if (send_allow[ob]) begin
      pulse(e);
    end
  endtask

  // bus error seen while receiving
  task automatic fault(input csr_lec_t code);
    csr_evt_t e;
    e = '0;
    e.err_code = code;
    e.err_valid = 1'b1;
    pulse(e);
  endtask

  // error counters and bus-off level
  task automatic set_err(input logic [7:0] t, input logic [7:0] rc,
                         input logic b);
    @(posedge clk);
    err <= '{tec: t, rec: rc, bus_off: b};
  endtask

  // host picks up one object
  task automatic take(input logic [4:0] ob);
    @(posedge clk);
    collect <= 1'b1;
    collect_obj <= ob;
    @(posedge clk);
    collect <= 1'b0;
  endtask
endmodule // csr_engine_model

// [bench/test_can_status_and_retransmit.sv]
`timescale 1ns/1ps
module test_can_status_and_retransmit;
  import csr_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, collect, status_int;
  logic retry_en;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, send_allow, recv_allow;
  logic [4:0] collect_obj, o, r;
  csr_evt_t evt;
  csr_err_t err;
  int fails = 0;
  int total_checks = 0;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  csr_top uut (
    .CLK_SYS(clk_sys), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EVT(evt), .ERR(err), .COLLECT(collect), .COLLECT_OBJ(collect_obj),
    .SEND_ALLOW(send_allow), .RECV_ALLOW(recv_allow),
    .RETRY_ENABLE(retry_en), .STATUS_INT(status_int)
  );

  csr_engine_model eng (
    .clk(clk_sys), .evt(evt), .err(err), .collect(collect),
    .collect_obj(collect_obj), .send_allow(send_allow)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    fails++;
    $display("MISMATCH %0t bus answer never came", $time);
    close_out();
  endtask

  // ready sampled at negedge equals what the next rising edge sees
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, done;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_sys);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      done = bvalid;
      rsp = bresp;
      @(posedge clk_sys);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) hang();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    logic ar_hit, done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge clk_sys);
      ar_hit = arvalid & arready;
      done = rvalid;
      d = rdata;
      rsp = rresp;
      @(posedge clk_sys);
      if (ar_hit) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) hang();
  endtask

  task automatic rcheck(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    axi_read(a, rd);
    check(rd & m, e);
  endtask

  task automatic cmd(input csr_op_t op, input logic [4:0] ob);
    axi_write(CSR_OFF_CMD, {22'h0, op, 3'h0, ob});
  endtask

  function automatic logic [31:0] bit_of(input logic [4:0] ob);
    return 32'h1 << ob;
  endfunction

  // expected state flags for given counters
  function automatic logic [31:0] flags_exp(input logic [7:0] t,
      input logic [7:0] rc, input logic b);
    logic [31:0] f;
    f = '0;
    f[CSR_BOFF_BIT] = b;
    f[CSR_EWARN_BIT] = (t >= CSR_WARN_LIMIT) || (rc >= CSR_WARN_LIMIT);
    f[CSR_EPASS_BIT] = ((t >= 8'h80) || (rc >= 8'h80)) && !b;
    return f;
  endfunction

  task automatic cnt_case(input logic [7:0] t, input logic [7:0] rc,
                          input logic b);
    eng.set_err(t, rc, b);
    rcheck(CSR_OFF_STATUS, 32'hE0, flags_exp(t, rc, b));
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h65b6));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rcheck(CSR_OFF_CTRL, 32'hFFFFFFFF, CSR_CTRL_RESET);
    rcheck(CSR_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    // every error code, its interrupt and the clearing read
    for (int c = 1; c < 7; c++) begin
      eng.fault(csr_lec_t'(c));
      @(negedge clk_sys);
      check({31'h0, status_int}, 32'h1);
      rcheck(CSR_OFF_CAUSE, 32'hFF, {24'h0, CSR_CAUSE_STATUS});
      rcheck(CSR_OFF_STATUS, 32'h7, 32'(c));
      @(negedge clk_sys);
      check({31'h0, status_int}, 32'h0);
    end
    // counter thresholds, corners first then random
    cnt_case(8'h5F, 8'h5F, 1'b0);
    cnt_case(8'h60, 8'h00, 1'b0);
    cnt_case(8'h00, 8'h60, 1'b0);
    cnt_case(8'h7F, 8'h80, 1'b0);
    cnt_case(8'h80, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      cnt_case(8'($urandom_range(135, 90)), 8'($urandom_range(135, 90)),
               1'($urandom));
    end
    cnt_case(8'h00, 8'h00, 1'b0);
    // retry on and off around errored frames
    r = 5'($urandom_range(31, 0));
    o = r ^ 5'h10;
    axi_write(CSR_OFF_CTRL, 32'h0);
    check({30'h0, rsp}, {30'h0, CSR_RESP_OKAY});
    rcheck(CSR_OFF_CTRL, 32'h1, 32'h0);
    check({31'h0, retry_en}, 32'h0);
    axi_write(CSR_OFF_CTRL, 32'h1);
    cmd(OP_CONFIG, o);
    rcheck(CSR_OFF_VALMAP, ~32'h0, bit_of(o));
    cmd(OP_SEND, o);
    rcheck(CSR_OFF_TXMAP, ~32'h0, bit_of(o));
    check(send_allow, bit_of(o));
    eng.transmit(o, 1'b1, LEC_NOACK);
    rcheck(CSR_OFF_TXMAP, ~32'h0, bit_of(o));
    axi_write(CSR_OFF_CTRL, 32'h0);
    eng.transmit(o, 1'b1, LEC_DOM_LOST);
    rcheck(CSR_OFF_TXMAP, ~32'h0, 32'h0);
    cmd(OP_SEND, o);
    eng.transmit(o, 1'b0, LEC_NONE);
    rcheck(CSR_OFF_TXMAP, ~32'h0, 32'h0);
    rcheck(CSR_OFF_STATUS, 32'h8, 32'h8);
    cmd(OP_SEND, r ^ 5'h01);
    check(send_allow & bit_of(r ^ 5'h01), 32'h0);
    cmd(OP_CLEAR, o);
    rcheck(CSR_OFF_VALMAP, ~32'h0, 32'h0);
    // reception, overrun, collection and cause
    cmd(OP_CONFIG, r);
    check(recv_allow, bit_of(r));
    eng.receive(r, 1'b1);
    rcheck(CSR_OFF_NEWMAP, ~32'h0, bit_of(r));
    rcheck(CSR_OFF_CAUSE, 32'hFF, {27'h0, r} + 32'h1);
    eng.receive(r, 1'b1);
    rcheck(CSR_OFF_LOST, ~32'h0, bit_of(r));
    eng.take(r);
    rcheck(CSR_OFF_NEWMAP, ~32'h0, 32'h0);
    rcheck(CSR_OFF_LOST, ~32'h0, 32'h0);
    rcheck(CSR_OFF_CAUSE, 32'hFF, 32'h0);
    eng.receive(r ^ 5'h01, 1'b1);
    rcheck(CSR_OFF_NEWMAP, ~32'h0, 32'h0);
    rcheck(CSR_OFF_STATUS, 32'h10, 32'h10);
    rcheck(CSR_OFF_STATUS, 32'h10, 32'h0);
    eng.receive(r, 1'b0);
    rcheck(CSR_OFF_STATUS, 32'h10, 32'h10);
    rcheck(CSR_OFF_STATUS, 32'h10, 32'h0);
    cmd(OP_CLEAR, r);
    rcheck(CSR_OFF_VALMAP, ~32'h0, 32'h0);
    check(recv_allow, 32'h0);
    // unmapped address answers with an error and zero data
    axi_read(8'h20, rd);
    check(rd, 32'h0);
    check({30'h0, rsp}, {30'h0, CSR_RESP_SLVERR});
    axi_write(8'h20, 32'h0);
    check({30'h0, rsp}, {30'h0, CSR_RESP_SLVERR});
    close_out();
  end
endmodule // test_can_status_and_retransmit

// [rtl/csr_axil.sv]
`timescale 1ns/1ps
// axi4-lite slave front end, one write and one read at a time
module csr_axil (
  input wire logic clk,
  input wire logic resetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_en,
  output logic [7:0] rd_addr
);
  logic aw_held;
  logic w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  // each channel taken once, in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      s_q <= 4'h0;
    end else if (wr_en) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
    end
  end

  assign wr_en = aw_held && w_held;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign wr_strb = s_q;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;

  // response one cycle after both halves are in
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid <= 1'b0;
    end else if (wr_en) begin
      bvalid <= 1'b1;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
    end else if (rd_en) begin
      rvalid <= 1'b1;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // csr_axil

// [rtl/csr_pkg.sv]
package csr_pkg;
  // register byte offsets
  localparam logic [7:0] CSR_OFF_STATUS = 8'h00;
  localparam logic [7:0] CSR_OFF_TXMAP = 8'h04;
  localparam logic [7:0] CSR_OFF_NEWMAP = 8'h08;
  localparam logic [7:0] CSR_OFF_VALMAP = 8'h0C;
  localparam logic [7:0] CSR_OFF_CTRL = 8'h10;
  localparam logic [7:0] CSR_OFF_CAUSE = 8'h14;
  localparam logic [7:0] CSR_OFF_LOST = 8'h18;
  localparam logic [7:0] CSR_OFF_CMD = 8'h1C;
  // status word field positions
  localparam int CSR_LEC_LSB = 0;
  localparam int CSR_TXOK_BIT = 3;
  localparam int CSR_RXOK_BIT = 4;
  localparam int CSR_EPASS_BIT = 5;
  localparam int CSR_EWARN_BIT = 6;
  localparam int CSR_BOFF_BIT = 7;
  // control and command fields
  localparam int CSR_RETRY_BIT = 0;
  localparam int CSR_CMD_OBJ_LSB = 0;
  localparam int CSR_CMD_OP_LSB = 8;
  // warning limit for either error counter
  localparam logic [7:0] CSR_WARN_LIMIT = 8'h60;
  // cause code for a status interrupt
  localparam logic [7:0] CSR_CAUSE_STATUS = 8'h80;
  localparam logic [31:0] CSR_CTRL_RESET = 32'h00000001;
  localparam logic [1:0] CSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;
  localparam int CSR_NOBJ = 32;

  // last-error codes
  typedef enum logic [2:0] {
    LEC_NONE = 3'h0,
    LEC_STUFF = 3'h1,
    LEC_FORM = 3'h2,
    LEC_NOACK = 3'h3,
    LEC_REC_OVR = 3'h4,
    LEC_DOM_LOST = 3'h5,
    LEC_CHECKSUM = 3'h6,
    LEC_UNCHANGED = 3'h7
  } csr_lec_t;

  // object commands from software
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_CONFIG = 2'h1,
    OP_CLEAR = 2'h2,
    OP_SEND = 2'h3
  } csr_op_t;

  // frame-level events from the protocol engine
  typedef struct packed {
    logic rx_done;
    logic [4:0] rx_obj;
    logic rx_match;
    logic tx_done;
    logic tx_err;
    logic [4:0] tx_obj;
    csr_lec_t err_code;
    logic err_valid;
  } csr_evt_t;

  // fault confinement state
  typedef struct packed {
    logic [7:0] tec;
    logic [7:0] rec;
    logic bus_off;
  } csr_err_t;

  // lowest set bit, returned as index
  function automatic logic [4:0] csr_first(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction
endpackage

// [rtl/csr_retry.sv]
`timescale 1ns/1ps
// decides whether a finished frame leaves its object pending
module csr_retry
  import csr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic retry_en,
  input wire csr_pkg::csr_evt_t evt,
  output logic [31:0] clr_mask,
  output logic retry_count_pulse
);
  // errored frame kept when retry on
  always_comb begin
    clr_mask = 32'h00000000;
    if (evt.tx_done && (!evt.tx_err || !retry_en)) begin
      clr_mask[evt.tx_obj] = 1'b1;
    end
  end

  // one pulse per frame kept for another try
  always_ff @(posedge clk) begin
    if (!resetn) begin
      retry_count_pulse <= 1'b0;
    end else begin
      retry_count_pulse <= evt.tx_done && evt.tx_err && retry_en;
    end
  end
endmodule // csr_retry

// [rtl/csr_top.sv]
`timescale 1ns/1ps
// Behaviour
// - with retry enabled, errored frames stay pending and are resent; else dropped
// - software reads back the retry enable bit
// - reading the status word clears a pending status interrupt
// - status word shows bus-off while in bus-off
// - warning flag set when either error counter is 96 or more
// - status word shows the error-passive state
// - receive-ok set on any correct frame, filter match or not
// - transmit-ok set on each successful transmission
// - three-bit last-error code, zero means no error
// - distinct codes for stuffing and format errors
// - distinct code for missing acknowledge
// - distinct code for recessive sent, dominant seen
// - distinct code for dominant sent, recessive seen
// - distinct code for checksum failure on reception
// - four 32-bit per-object maps readable besides the status word
// - transmit map bit set while object send is pending
// - fresh-data map bit set until host collects the message
// - configured map bit set for a valid object, clear if unused
// - cause reads status code, or 1..32 for lowest pending object
// - unconfigured object neither sends, receives nor interrupts
// - object flags overrun when unread data is overwritten
module csr_top
  import csr_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // axi4-lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // protocol engine side
  input wire csr_pkg::csr_evt_t EVT,
  input wire csr_pkg::csr_err_t ERR,
  input wire logic COLLECT,
  input wire logic [4:0] COLLECT_OBJ,
  output logic [31:0] SEND_ALLOW,
  output logic [31:0] RECV_ALLOW,
  output logic RETRY_ENABLE,
  output logic STATUS_INT
);
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [7:0] rd_addr;
  logic retry_en;
  logic bus_off;
  logic ewarn;
  logic epass;
  logic rx_ok;
  logic tx_ok;
  csr_lec_t lec;
  logic stat_int;
  logic [31:0] tx_map;
  logic [31:0] new_map;
  logic [31:0] val_map;
  logic [31:0] lost_map;
  logic [31:0] int_map;
  logic [31:0] clr_mask;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] wresp;
  logic [31:0] status_word;
  logic [7:0] cause;
  logic cmd_wr;
  csr_op_t cmd_op;
  logic [4:0] cmd_obj;
  logic rx_take;
  logic tx_take;
  logic status_rd;

  csr_axil u_bus (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_en(rd_en),
    .rd_addr(rd_addr)
  );

  csr_retry u_retry (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .retry_en(retry_en),
    .evt(EVT),
    .clr_mask(clr_mask),
    .retry_count_pulse()
  );

  // control register: retry enable, reset value enabled
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      retry_en <= CSR_CTRL_RESET[CSR_RETRY_BIT];
    end else if (wr_en && wr_addr == CSR_OFF_CTRL && wr_strb[0]) begin
      retry_en <= wr_data[CSR_RETRY_BIT];
    end
  end
  assign RETRY_ENABLE = retry_en;

  // command register decode
  assign cmd_wr = wr_en && wr_addr == CSR_OFF_CMD && wr_strb[1];
  assign cmd_op = csr_op_t'(wr_data[CSR_CMD_OP_LSB +: 2]);
  assign cmd_obj = wr_data[CSR_CMD_OBJ_LSB +: 5];
  assign status_rd = rd_en && rd_addr == CSR_OFF_STATUS;

  assign rx_take = EVT.rx_done && EVT.rx_match && val_map[EVT.rx_obj];
  assign tx_take = EVT.tx_done && val_map[EVT.tx_obj];

  // configured map follows config and clear commands
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      val_map <= 32'h00000000;
    end else if (cmd_wr && cmd_op == OP_CONFIG) begin
      val_map[cmd_obj] <= 1'b1;
    end else if (cmd_wr && cmd_op == OP_CLEAR) begin
      val_map[cmd_obj] <= 1'b0;
    end
  end

  // pending until sent; keeps it on error with retry
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      tx_map <= 32'h00000000;
    end else begin
      tx_map <= tx_map & ~(tx_take ? clr_mask : 32'h00000000) & val_map;
      if (cmd_wr && cmd_op == OP_SEND && val_map[cmd_obj]) begin
        tx_map[cmd_obj] <= 1'b1;
      end
    end
  end
  assign SEND_ALLOW = tx_map & val_map;
  assign RECV_ALLOW = val_map;

  // fresh data; set wins over collect in the same cycle
  // overrun when a fresh slot is overwritten
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      new_map <= 32'h00000000;
      lost_map <= 32'h00000000;
      int_map <= 32'h00000000;
    end else begin
      if (COLLECT) begin
        new_map[COLLECT_OBJ] <= 1'b0;
        lost_map[COLLECT_OBJ] <= 1'b0;
        int_map[COLLECT_OBJ] <= 1'b0;
      end
      if (cmd_wr && cmd_op == OP_CLEAR) begin
        int_map[cmd_obj] <= 1'b0;
      end
      if (rx_take) begin
        new_map[EVT.rx_obj] <= 1'b1;
        int_map[EVT.rx_obj] <= 1'b1;
        if (new_map[EVT.rx_obj]) begin
          lost_map[EVT.rx_obj] <= 1'b1;
        end
      end
      if (tx_take && !EVT.tx_err) begin
        int_map[EVT.tx_obj] <= 1'b1;
      end
    end
  end

  // confinement state; warning at counter 96
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      bus_off <= 1'b0;
      ewarn <= 1'b0;
      epass <= 1'b0;
    end else begin
      bus_off <= ERR.bus_off;
      ewarn <= ERR.tec >= CSR_WARN_LIMIT || ERR.rec >= CSR_WARN_LIMIT;
      epass <= !ERR.bus_off && (ERR.tec[7] || ERR.rec[7]);
    end
  end

  // sticky flags, cleared by status read; set wins
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rx_ok <= 1'b0;
      tx_ok <= 1'b0;
    end else begin
      if (status_rd) begin
        rx_ok <= 1'b0;
        tx_ok <= 1'b0;
      end
      if (EVT.rx_done) begin
        rx_ok <= 1'b1;
      end
      if (EVT.tx_done && !EVT.tx_err) begin
        tx_ok <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      lec <= LEC_NONE;
    end else if (EVT.err_valid) begin
      lec <= EVT.err_code;
    end else if (EVT.rx_done || (EVT.tx_done && !EVT.tx_err)) begin
      lec <= LEC_NONE;
    end
  end

  // status interrupt on error code or bus-off change, cleared by read
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      stat_int <= 1'b0;
    end else if (EVT.err_valid || bus_off != ERR.bus_off) begin
      stat_int <= 1'b1;
    end else if (status_rd) begin
      stat_int <= 1'b0;
    end
  end
  assign STATUS_INT = stat_int;

  // status code first, else lowest object number pending
  always_comb begin
    if (stat_int) begin
      cause = CSR_CAUSE_STATUS;
    end else if (int_map != 32'h00000000) begin
      cause = {3'h0, csr_first(int_map)} + 8'h01;
    end else begin
      cause = 8'h00;
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[CSR_LEC_LSB +: 3] = lec;
    status_word[CSR_TXOK_BIT] = tx_ok;
    status_word[CSR_RXOK_BIT] = rx_ok;
    status_word[CSR_EPASS_BIT] = epass;
    status_word[CSR_EWARN_BIT] = ewarn;
    status_word[CSR_BOFF_BIT] = bus_off;
  end

  // read mux; maps readable; unmapped returns slverr
  always_comb begin
    next_rresp = CSR_RESP_OKAY;
    case (rd_addr)
      CSR_OFF_STATUS: next_rdata = status_word;
      CSR_OFF_TXMAP: next_rdata = tx_map;
      CSR_OFF_NEWMAP: next_rdata = new_map;
      CSR_OFF_VALMAP: next_rdata = val_map;
      CSR_OFF_CTRL: next_rdata = {31'h00000000, retry_en};
      CSR_OFF_CAUSE: next_rdata = {24'h000000, cause};
      CSR_OFF_LOST: next_rdata = lost_map;
      CSR_OFF_CMD: next_rdata = 32'h00000000;
      default: begin
        next_rdata = 32'h00000000;
        next_rresp = CSR_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= CSR_RESP_OKAY;
    end else if (rd_en) begin
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end
  end

  always_comb begin
    case (wr_addr)
      CSR_OFF_CTRL, CSR_OFF_CMD: wresp = CSR_RESP_OKAY;
      CSR_OFF_STATUS, CSR_OFF_TXMAP, CSR_OFF_NEWMAP: wresp = CSR_RESP_OKAY;
      CSR_OFF_VALMAP, CSR_OFF_CAUSE, CSR_OFF_LOST: wresp = CSR_RESP_OKAY;
      default: wresp = CSR_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      S_AXI_BRESP <= CSR_RESP_OKAY;
    end else if (wr_en) begin
      S_AXI_BRESP <= wresp;
    end
  end

  // errored frame on a configured object, no command racing it
  sequence err_frame_s;
    tx_take && EVT.tx_err && !cmd_wr;
  endsequence

  // errored frame stays pending when retry on
  retry_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    err_frame_s ##0 (retry_en && tx_map[EVT.tx_obj])
    |=> tx_map[$past(EVT.tx_obj)]) else $error("retry lost pending");
  retry_drop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    err_frame_s ##0 !retry_en
    |=> !tx_map[$past(EVT.tx_obj)]) else $error("errored frame kept");
  read_clears_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    status_rd && !EVT.err_valid && bus_off == ERR.bus_off
    |=> !stat_int) else $error("status int not cleared");
  warn_limit_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ERR.tec >= CSR_WARN_LIMIT) |=> ewarn) else $error("warning missed");
  rx_ok_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    EVT.rx_done |=> rx_ok) else $error("rx ok not set");
  tx_ok_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    EVT.tx_done && !EVT.tx_err |=> tx_ok) else $error("tx ok not set");
  // send request on an unconfigured object is refused
  unused_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    cmd_wr && cmd_op == OP_SEND && !val_map[cmd_obj]
    |=> !SEND_ALLOW[$past(cmd_obj)]) else $error("invalid obj pending");
  overrun_set_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    rx_take && new_map[EVT.rx_obj]
    |=> lost_map[$past(EVT.rx_obj)]) else $error("overrun missed");
endmodule // csr_top
